// ---- sbp_pkg.sv ----
// constants, types and the map of the slave bus port
// Overview of operation
// - slave select makes data port parallel slave
// - port E pins become read, write, select
// - firmware sets E inputs and digital pins
// - output latch and input latch, one address
// - slave mode ignores data direction register
// - select plus write low reads live pins
// - write release latches data, flags at phase four
// - reading data clears input full flag
// - write while full sets overrun, overwrites
// - firmware clears overrun by writing zero
// - select plus read low drives output latch
// - firmware write during read shows at once
// - read release stops drive, flags irq later
// - output full stays low until firmware writes while no read is active
// - outside slave mode full flags held clear
// - irq flag firmware cleared, enable masks it
// - select and strobes are active low
// - full flags and bit 3 read only, rest read write
package sbp_pkg;
   // ************************************************
   // register indices, byte address is index times four
   // ************************************************
   localparam logic [7:0]  IDX_PORT_DATA   = 8'h08;
   localparam logic [7:0]  IDX_PORT_E      = 8'h09;
   localparam logic [7:0]  IDX_IRQ_FLAGS   = 8'h0c;
   localparam logic [7:0]  IDX_PORT_E_CTRL = 8'h89;
   localparam logic [7:0]  IDX_PORT_D_DIR  = 8'h88;
   localparam logic [7:0]  IDX_IRQ_EN      = 8'h8c;
   localparam logic [7:0]  IDX_ANALOG      = 8'h9f;
   localparam int unsigned ADDR_W          = 12;
   // ************************************************
   // field positions and values after reset
   // ************************************************
   localparam int unsigned BIT_IN_FULL     = 7;
   localparam int unsigned BIT_OUT_FULL    = 6;
   localparam int unsigned BIT_OVERRUN     = 5;
   localparam int unsigned BIT_SLAVE_SEL   = 4;
   localparam int unsigned BIT_SLAVE_IRQ   = 7;
   localparam logic [7:0]  CTRL_WR_MASK    = 8'h37;
   localparam logic [7:0]  RST_PORT_E_CTRL = 8'h07;
   localparam logic [7:0]  RST_PORT_D_DIR  = 8'hff;
   localparam logic [7:0]  RST_IRQ_FLAGS   = 8'h00;
   localparam logic [7:0]  RST_IRQ_EN      = 8'h00;
   localparam logic [7:0]  RST_ANALOG      = 8'h00;
   // ************************************************
   // phase clock and host strobe timing, in clk cycles
   // ************************************************
   localparam logic [1:0]  PHASE_TWO       = 2'h1;
   localparam logic [1:0]  PHASE_FOUR      = 2'h3;
   localparam logic [3:0]  HOST_SETUP_CYC  = 4'h2;
   localparam logic [3:0]  HOST_STROBE_CYC = 4'h6;
   localparam logic [3:0]  HOST_HOLD_CYC   = 4'h2;
   typedef enum logic {APB_IDLE, APB_ANSWER} sbp_apb_state_t;
   typedef enum logic [1:0] {H_IDLE, H_SETUP, H_STROBE, H_HOLD} sbp_host_state_t;
endpackage

// ---- sbp_if.sv ----
// pins between the external master and the slave bus port
`timescale 1ns/1ps
interface sbp_if;
   logic       chipSelectN;
   logic       readStrobeN;
   logic       writeStrobeN;
   logic [7:0] hostData;
   logic       hostOe;
   logic [7:0] devData;
   logic [7:0] devOe;
   logic [7:0] data;
   // undriven bits float high, as a pull-up would make them
   assign data = (devData & devOe) | (hostData & {8{hostOe}} & ~devOe)
                 | ~(devOe | {8{hostOe}});
   modport dev  (input chipSelectN, readStrobeN, writeStrobeN, data,
                 output devData, devOe);
   modport host (output chipSelectN, readStrobeN, writeStrobeN, hostData, hostOe,
                 input data);
endinterface

// ---- sbp_sync.sv ----
// two flip-flop synchroniser, one per bit
`timescale 1ns/1ps
module sbp_sync #(
   parameter int unsigned W       = 3,
   parameter logic [W-1:0] RST_VAL = '1
) (
   input  wire logic         clk,
   input  wire logic         rstn,
   input  wire logic         ce,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_q;
   genvar i;
   for (i = 0; i < W; i++)
   begin : g_bit
      always_ff @(posedge clk)
      begin
         if (!rstn)
         begin
            meta_q[i] <= RST_VAL[i];
            q[i]      <= RST_VAL[i];
         end
         else if (ce)
         begin
            meta_q[i] <= d[i];
            q[i]      <= meta_q[i];
         end
      end
   end
endmodule // sbp_sync

// ---- sbp_device.sv ----
// slave bus port end: pin logic, flags and apb register file
`timescale 1ns/1ps
module sbp_device
   import sbp_pkg::*;
(
   input  wire logic                clk,
   input  wire logic                rstn,
   input  wire logic                ce,
   sbp_if.dev                       link,
   input  wire logic                psel,
   input  wire logic                penable,
   input  wire logic                pwrite,
   input  wire logic [ADDR_W-1:0]   paddr,
   input  wire logic [31:0]         pwdata,
   output logic      [31:0]         prdata,
   output logic                     pready,
   output logic                     pslverr,
   output logic                     irq
);
   import sbp_pkg::*;
   // ************************************************
   // strobe synchronisation and active levels
   // ************************************************
   logic [2:0] strobeS;
   logic       slaveMode;
   logic       wrAct;
   logic       rdAct;
   logic       wrAct_q;
   logic       rdAct_q;
   logic [1:0] evDone;
   logic [1:0] evPend_q;
   logic [1:0] evArm_q;
   logic [1:0] evFire;
   logic [1:0] phase_q;
   logic [7:0] pinShadow_q;
   logic [7:0] inLatch_q;
   logic [7:0] outLatch_q;
   logic [7:0] ctrl_q;
   logic [7:0] dirD_q;
   logic [7:0] irqFlags_q;
   logic [7:0] irqEn_q;
   logic [7:0] analog_q;
   logic       inFull_q;
   logic       outFull_q;
   logic       overrun_q;
   sbp_apb_state_t apbState_q;
   logic [7:0] rdVal;
   logic       hit;
   logic       acc;
   logic       accWr;
   logic       accRd;
   logic [7:0] accIdx;

   // bit 0 read, bit 1 write, bit 2 chip select, as on port E
   sbp_sync #(
      .W       (3),
      .RST_VAL (3'h7)
   ) u_strobeSync (
      .clk  (clk),
      .rstn (rstn),
      .ce   (ce),
      .d    ({link.chipSelectN, link.writeStrobeN, link.readStrobeN}),
      .q    (strobeS)
   );

   assign slaveMode = ctrl_q[BIT_SLAVE_SEL];
   assign wrAct     = slaveMode & ~strobeS[2] & ~strobeS[1];
   assign rdAct     = slaveMode & ~strobeS[2] & ~strobeS[0];
   // release is level sensed: either line high ends the cycle
   assign evDone    = {rdAct_q & ~rdAct, wrAct_q & ~wrAct};

   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         wrAct_q <= 1'b0;
         rdAct_q <= 1'b0;
         phase_q <= 2'h0;
      end
      else if (ce)
      begin
         wrAct_q <= wrAct;
         rdAct_q <= rdAct;
         phase_q <= phase_q + 2'h1;
      end
   end

   // ************************************************
   // completion events land on phase four after phase two
   // ************************************************
   genvar e;
   for (e = 0; e < 2; e++)
   begin : g_event
      assign evFire[e] = evArm_q[e] & (phase_q == PHASE_FOUR);
      always_ff @(posedge clk)
      begin
         if (!rstn)
         begin
            evPend_q[e] <= 1'b0;
            evArm_q[e]  <= 1'b0;
         end
         else if (ce)
         begin
            evPend_q[e] <= evDone[e] | (evPend_q[e] & (phase_q != PHASE_TWO));
            evArm_q[e]  <= (evPend_q[e] & (phase_q == PHASE_TWO))
                           | (evArm_q[e] & ~evFire[e]);
         end
      end
   end

   // ************************************************
   // data path latches
   // ************************************************
   // shadow follows the pins while the write is active, so the byte is
   // the one present before the release reached the synchroniser
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         pinShadow_q <= 8'h00;
         inLatch_q   <= 8'h00;
      end
      else if (ce)
      begin
         if (wrAct)
            pinShadow_q <= link.data;
         if (evDone[0])
            inLatch_q <= pinShadow_q;
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rstn)
         outLatch_q <= 8'h00;
      else if (ce && accWr && accIdx == IDX_PORT_DATA)
         outLatch_q <= pwdata[7:0];
   end

   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         link.devData <= 8'h00;
         link.devOe   <= 8'h00;
      end
      else if (ce)
      begin
         link.devData <= (accWr && accIdx == IDX_PORT_DATA) ? pwdata[7:0] : outLatch_q;
         link.devOe   <= slaveMode ? {8{rdAct}} : ~dirD_q;
      end
   end

   // ************************************************
   // status flags
   // ************************************************
   always_ff @(posedge clk)
   begin
      if (!rstn)
         inFull_q <= 1'b0;
      else if (ce)
      begin
         if (!slaveMode)
            inFull_q <= 1'b0;
         else if (evFire[0])
            inFull_q <= 1'b1;
         else if (accRd && accIdx == IDX_PORT_DATA && !wrAct)
            inFull_q <= 1'b0;
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rstn)
         outFull_q <= 1'b0;
      else if (ce)
      begin
         if (!slaveMode)
            outFull_q <= 1'b0;
         else if (rdAct)
            outFull_q <= 1'b0;
         else if (accWr && accIdx == IDX_PORT_DATA)
            outFull_q <= 1'b1;
      end
   end

   // a write still waiting for its phase counts as unread too
   always_ff @(posedge clk)
   begin
      if (!rstn)
         overrun_q <= 1'b0;
      else if (ce)
      begin
         if (evDone[0] && (inFull_q || evPend_q[0] || evArm_q[0]))
            overrun_q <= 1'b1;
         else if (accWr && accIdx == IDX_PORT_E_CTRL)
            overrun_q <= pwdata[BIT_OVERRUN];
      end
   end

   // ************************************************
   // software registers
   // ************************************************
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         ctrl_q   <= RST_PORT_E_CTRL;
         dirD_q   <= RST_PORT_D_DIR;
         irqEn_q  <= RST_IRQ_EN;
         analog_q <= RST_ANALOG;
      end
      else if (ce && accWr)
      begin
         if (accIdx == IDX_PORT_E_CTRL)
            ctrl_q <= pwdata[7:0] & CTRL_WR_MASK;
         if (accIdx == IDX_PORT_D_DIR)
            dirD_q <= pwdata[7:0];
         if (accIdx == IDX_IRQ_EN)
            irqEn_q <= pwdata[7:0];
         if (accIdx == IDX_ANALOG)
            analog_q <= pwdata[7:0];
      end
   end

   // a read clears only the bits it returned, so an event that lands
   // between setup and access is not lost; same-cycle set still wins
   always_ff @(posedge clk)
   begin
      if (!rstn)
         irqFlags_q <= RST_IRQ_FLAGS;
      else if (ce)
      begin
         if (accRd && accIdx == IDX_IRQ_FLAGS)
            irqFlags_q <= irqFlags_q & ~prdata[7:0];
         else if (accWr && accIdx == IDX_IRQ_FLAGS)
            irqFlags_q <= pwdata[7:0];
         if (|evFire)
            irqFlags_q[BIT_SLAVE_IRQ] <= 1'b1;
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rstn)
         irq <= 1'b0;
      else if (ce)
         irq <= |(irqFlags_q & irqEn_q);
   end

   // ************************************************
   // apb slave, answers in the first cycle of the access phase
   // ************************************************
   assign acc    = psel & penable & pready;
   assign accWr  = acc & pwrite & ~pslverr;
   assign accRd  = acc & ~pwrite & ~pslverr;
   assign accIdx = paddr[9:2];

   always_comb
   begin
      hit   = (paddr[1:0] == 2'h0) && (paddr[ADDR_W-1:10] == '0);
      rdVal = 8'h00;
      case (paddr[9:2])
         IDX_PORT_DATA:   rdVal = (wrAct || !slaveMode) ? link.data : inLatch_q;
         IDX_PORT_E:      rdVal = {5'h00, strobeS};
         IDX_IRQ_FLAGS:   rdVal = irqFlags_q;
         IDX_PORT_E_CTRL: rdVal = {inFull_q, outFull_q, overrun_q, ctrl_q[4:0]};
         IDX_PORT_D_DIR:  rdVal = dirD_q;
         IDX_IRQ_EN:      rdVal = irqEn_q;
         IDX_ANALOG:      rdVal = analog_q;
         default:         hit = 1'b0;
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         apbState_q <= APB_IDLE;
         pready     <= 1'b0;
         pslverr    <= 1'b0;
         prdata     <= 32'h0000_0000;
      end
      else if (ce)
      begin
         case (apbState_q)
            APB_IDLE:
               if (psel && !penable)
               begin
                  apbState_q <= APB_ANSWER;
                  pready     <= 1'b1;
                  pslverr    <= ~hit;
                  prdata     <= {24'h00_0000, hit ? rdVal : 8'h00};
               end
            APB_ANSWER:
            begin
               apbState_q <= APB_IDLE;
               pready     <= 1'b0;
               pslverr    <= 1'b0;
            end
            default:
               apbState_q <= APB_IDLE;
         endcase
      end
   end
endmodule // sbp_device

// ---- sbp_host.sv ----
// external master end: turns byte requests into strobe cycles
`timescale 1ns/1ps
module sbp_host
   import sbp_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rstn,
   input  wire logic       ce,
   sbp_if.host             link,
   input  wire logic       reqValid,
   input  wire logic       reqWrite,
   input  wire logic [7:0] reqData,
   output logic            reqReady,
   output logic            rspValid,
   output logic [7:0]      rspData
);
   import sbp_pkg::*;
   sbp_host_state_t state_q;
   logic [3:0]      cnt_q;
   logic            isWrite_q;

   // ************************************************
   // strobe sequencer
   // ************************************************
   // strobe width covers the far end's synchroniser and output register
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         state_q            <= H_IDLE;
         cnt_q              <= 4'h0;
         isWrite_q          <= 1'b0;
         reqReady           <= 1'b0;
         rspValid           <= 1'b0;
         rspData            <= 8'h00;
         link.chipSelectN   <= 1'b1;
         link.readStrobeN   <= 1'b1;
         link.writeStrobeN  <= 1'b1;
         link.hostData      <= 8'h00;
         link.hostOe        <= 1'b0;
      end
      else if (ce)
      begin
         rspValid <= 1'b0;
         case (state_q)
            H_IDLE:
            begin
               reqReady <= 1'b1;
               if (reqValid && reqReady)
               begin
                  reqReady         <= 1'b0;
                  isWrite_q        <= reqWrite;
                  link.hostData    <= reqData;
                  link.hostOe      <= reqWrite;
                  link.chipSelectN <= 1'b0;
                  cnt_q            <= HOST_SETUP_CYC - 4'h1;
                  state_q          <= H_SETUP;
               end
            end
            H_SETUP:
               if (cnt_q == 4'h0)
               begin
                  link.readStrobeN  <= isWrite_q;
                  link.writeStrobeN <= ~isWrite_q;
                  cnt_q             <= HOST_STROBE_CYC - 4'h1;
                  state_q           <= H_STROBE;
               end
               else
                  cnt_q <= cnt_q - 4'h1;
            H_STROBE:
               if (cnt_q == 4'h0)
               begin
                  if (!isWrite_q)
                  begin
                     rspData  <= link.data;
                     rspValid <= 1'b1;
                  end
                  link.readStrobeN  <= 1'b1;
                  link.writeStrobeN <= 1'b1;
                  link.chipSelectN  <= 1'b1;
                  cnt_q             <= HOST_HOLD_CYC - 4'h1;
                  state_q           <= H_HOLD;
               end
               else
                  cnt_q <= cnt_q - 4'h1;
            H_HOLD:
               if (cnt_q == 4'h0)
               begin
                  link.hostOe <= 1'b0;
                  state_q     <= H_IDLE;
               end
               else
                  cnt_q <= cnt_q - 4'h1;
            default:
               state_q <= H_IDLE;
         endcase
      end
   end
endmodule // sbp_host

// ---- sbp_props.sv ----
// checker on the pins between the slave bus port and its master
`timescale 1ns/1ps
module sbp_props (
   input wire logic       clk,
   input wire logic       rstn,
   input wire logic       chipSelectN,
   input wire logic       readStrobeN,
   input wire logic       writeStrobeN,
   input wire logic       hostOe,
   input wire logic [7:0] devOe
);
   // ************************************************
   // pin relations, one clock domain
   // ************************************************
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rstn);
   logic rdAct;
   assign rdAct = !chipSelectN && !readStrobeN;
   chk_select_lead: assert property ($fell(readStrobeN) || $fell(writeStrobeN)
      |-> !$past(chipSelectN) && !$past(chipSelectN, 2)) else $error("strobe without select lead");
   chk_write_width: assert property ($fell(writeStrobeN)
      |-> !writeStrobeN [*6] ##1 writeStrobeN) else $error("write strobe width wrong");
   chk_read_width: assert property ($fell(readStrobeN)
      |-> !readStrobeN [*6] ##1 readStrobeN) else $error("read strobe width wrong");
   // the synchroniser makes the drive lag the strobe by a fixed three cycles
   chk_drive_start: assert property ($rose(devOe == 8'hff) |-> $past(rdAct, 3))
      else $error("data driven without an external read");
   chk_drive_hold: assert property (rdAct && $past(rdAct, 3) |-> devOe == 8'hff)
      else $error("data not driven during external read");
   chk_drive_stop: assert property ($rose(readStrobeN) |-> ##3 devOe == 8'h00)
      else $error("data still driven after read release");
   chk_write_drive: assert property (!writeStrobeN |-> hostOe && devOe == 8'h00)
      else $error("bus contention during external write");
   chk_data_hold: assert property ($rose(writeStrobeN) |-> hostOe [*2] ##1 !hostOe)
      else $error("write data hold wrong");
   chk_select_end: assert property ($rose(readStrobeN) || $rose(writeStrobeN)
      |-> $rose(chipSelectN)) else $error("select not released with strobe");
   chk_idle_strobes: assert property (chipSelectN |-> readStrobeN && writeStrobeN)
      else $error("strobe active while deselected");
   cov_write: cover property ($rose(writeStrobeN));
   cov_read: cover property ($rose(devOe == 8'hff));
   cov_release: cover property ($rose(readStrobeN) ##3 devOe == 8'h00);
endmodule // sbp_props

// ---- sbp_tb.sv ----
// self-checking bench for both ends of the slave bus port
`timescale 1ns/1ps
`define CHK(n, e, g) begin totalChecks++; if ((g) !== (e)) begin miscompares++; \
   $display("mismatch %s expected %h seen %h", n, e, g); end end
module testbench;
   import sbp_pkg::*;
   logic        clk, rstn, ce, psel, penable, pwrite, pready, pslverr, irq;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rdv;
   logic        reqValid, reqWrite, reqReady, rspValid, errv;
   logic [7:0]  reqData, rspData, hostRd;
   int          miscompares, totalChecks;
   sbp_if link();
   sbp_device u_sbp_device(.clk, .rstn, .ce, .link(link), .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .irq);
   sbp_host u_sbp_host(.clk, .rstn, .ce, .link(link), .reqValid, .reqWrite, .reqData,
      .reqReady, .rspValid, .rspData);
   sbp_props u_sbp_props(.clk, .rstn, .chipSelectN(link.chipSelectN),
      .readStrobeN(link.readStrobeN), .writeStrobeN(link.writeStrobeN),
      .hostOe(link.hostOe), .devOe(link.devOe));
   // ************************************************
   // bus tasks
   // ************************************************
   function automatic logic [11:0] ad(input logic [7:0] idx);
      return {2'b00, idx, 2'b00};
   endfunction
   task automatic idle(input int k);
      repeat (k) @(posedge clk);
   endtask
   // outputs are read right after the edge, before its flop updates land
   task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] wd);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h000000, wd};
      @(posedge clk);
      penable <= 1'b1;
      do
      begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) miscompares++;
      rdv = prdata;
      errv = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr_reg(input logic [7:0] idx, input logic [7:0] v);
      apb(1'b1, ad(idx), v);
   endtask
   task automatic chk_reg(input logic [7:0] idx, input logic [7:0] e);
      apb(1'b0, ad(idx), 8'h00);
      `CHK($sformatf("reg %h", idx), {24'h000000, e}, rdv)
   endtask
   // returns only once the host is idle again, so strobe cycles never overlap
   task automatic host(input logic w, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge clk);
      reqValid <= 1'b1;
      reqWrite <= w;
      reqData <= d;
      do @(posedge clk); while (reqReady !== 1'b1);
      reqValid <= 1'b0;
      do
      begin
         @(posedge clk);
         n++;
         if (rspValid === 1'b1) hostRd = rspData;
      end while (reqReady !== 1'b1 && n < 50);
      if (n >= 50) miscompares++;
   endtask
   task automatic stop_test;
      $display("checks %0d mismatches %0d", totalChecks, miscompares);
      if (miscompares == 0 && totalChecks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // ************************************************
   // clock, watchdog and tests
   // ************************************************
   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   initial
   begin
      idle(5000);
      miscompares++;
      stop_test;
   end
   initial
   begin
      {rstn, psel, penable, pwrite, reqValid, reqWrite} = '0;
      {ce, paddr, pwdata, reqData, hostRd} = {1'b1, 60'h0};
      idle(10);
      rstn <= 1'b1;
      chk_reg(IDX_PORT_E_CTRL, RST_PORT_E_CTRL);
      chk_reg(IDX_PORT_D_DIR, RST_PORT_D_DIR);
      chk_reg(IDX_IRQ_FLAGS, RST_IRQ_FLAGS);
      chk_reg(IDX_IRQ_EN, RST_IRQ_EN);
      chk_reg(IDX_ANALOG, RST_ANALOG);
      chk_reg(IDX_PORT_E, 8'h07);
      apb(1'b0, 12'h3fc, 8'h00);
      `CHK("unmapped error", 1'b1, errv)
      `CHK("unmapped data", 32'h0, rdv)
      apb(1'b0, 12'h021, 8'h00);
      `CHK("misaligned error", 1'b1, errv)
      `CHK("irq", 1'b0, irq)
      $display("test reset done");
      wr_reg(IDX_PORT_E_CTRL, 8'hff);
      chk_reg(IDX_PORT_E_CTRL, 8'h37);
      wr_reg(IDX_PORT_E_CTRL, 8'h17);
      chk_reg(IDX_PORT_E_CTRL, 8'h17);
      wr_reg(IDX_PORT_D_DIR, 8'h00);
      idle(3);
      `CHK("drive enable", 8'h00, link.devOe)
      wr_reg(IDX_PORT_D_DIR, 8'hff);
      $display("test access done");
      wr_reg(IDX_IRQ_EN, 8'h80);
      host(1'b1, 8'ha5);
      idle(12);
      chk_reg(IDX_PORT_E_CTRL, 8'h97);
      `CHK("irq", 1'b1, irq)
      chk_reg(IDX_IRQ_FLAGS, 8'h80);
      chk_reg(IDX_PORT_DATA, 8'ha5);
      chk_reg(IDX_PORT_E_CTRL, 8'h17);
      `CHK("irq", 1'b0, irq)
      $display("test write done");
      host(1'b1, 8'h11);
      idle(12);
      host(1'b1, 8'h22);
      idle(12);
      chk_reg(IDX_PORT_E_CTRL, 8'hb7);
      chk_reg(IDX_PORT_DATA, 8'h22);
      chk_reg(IDX_PORT_E_CTRL, 8'h37);
      wr_reg(IDX_PORT_E_CTRL, 8'h17);
      chk_reg(IDX_PORT_E_CTRL, 8'h17);
      chk_reg(IDX_IRQ_FLAGS, 8'h80);
      $display("test overrun done");
      wr_reg(IDX_PORT_DATA, 8'h3c);
      chk_reg(IDX_PORT_E_CTRL, 8'h57);
      host(1'b0, 8'h00);
      `CHK("host read", 8'h3c, hostRd)
      idle(12);
      chk_reg(IDX_PORT_E_CTRL, 8'h17);
      chk_reg(IDX_IRQ_FLAGS, 8'h80);
      wr_reg(IDX_IRQ_EN, 8'h00);
      // firmware rewrites the output latch while the host read is active
      fork
         host(1'b0, 8'h00);
         begin
            idle(4);
            wr_reg(IDX_PORT_DATA, 8'hc3);
         end
      join
      `CHK("host read late", 8'hc3, hostRd)
      idle(12);
      `CHK("irq masked", 1'b0, irq)
      chk_reg(IDX_PORT_E_CTRL, 8'h17);
      chk_reg(IDX_IRQ_FLAGS, 8'h80);
      chk_reg(IDX_IRQ_FLAGS, 8'h00);
      $display("test read done");
      fork
         host(1'b1, 8'h5a);
         begin
            idle(6);
            chk_reg(IDX_PORT_DATA, 8'h5a);
         end
      join
      idle(12);
      chk_reg(IDX_PORT_DATA, 8'h5a);
      chk_reg(IDX_IRQ_FLAGS, 8'h80);
      $display("test live done");
      wr_reg(IDX_PORT_E_CTRL, 8'h27);
      chk_reg(IDX_PORT_E_CTRL, 8'h27);
      host(1'b1, 8'h99);
      wr_reg(IDX_PORT_DATA, 8'h44);
      idle(12);
      chk_reg(IDX_PORT_E_CTRL, 8'h27);
      chk_reg(IDX_IRQ_FLAGS, 8'h00);
      wr_reg(IDX_PORT_D_DIR, 8'h0f);
      idle(3);
      `CHK("drive enable", 8'hf0, link.devOe)
      wr_reg(IDX_PORT_D_DIR, 8'hff);
      $display("test port mode done");
      stop_test;
   end
endmodule // testbench
